// *** ssl_core.sv ***
// Lock, lock-status and unique-serial instructions of the SPI slave.
// Assumes SPI pins are asynchronous to clk_i and are oversampled.
`timescale 1ns/100ps
// What this block does
// [R1] Lock only when write-enable latch is set
// [R2] Host sends 82h, address, one data byte
// [R3] Lock needs address bits 10:9 equal 10
// [R4] Lock needs data bit 1 set
// [R5] Select must rise right after eighth bit
// [R6] No lock when protect 11 or locked
// [R7] Lock is permanent, region becomes read-only
// [R8] 83h with bits 10:9 = 10 reads status
// [R9] Status bit 1 shows lock state
// [R10] Status byte repeats while select low
// [R11] 83h with bit 9 reads serial
// [R12] Shift fixed 128-bit serial on falling edges
// [R13] Serial byte index wraps after sixteen
// [R14] Select high ends read, output released
// [R15] Sample rising, drive falling, MSB first
// [R16] Opcode 06h sets write-enable latch
// [R17] Bits 10:9 = 00 selects sector data access
// [R18] Lock kept nonvolatile, zero when fresh
// [R19] Bit 9 checked before 10/00 patterns
module ssl_core #(
   parameter logic [127:0] UID_VALUE = ssl_pkg::UID_DEFAULT
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // SPI pins
   input wire logic select_n_i,
   input wire logic sclk_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_en_o,
   // Shared status bits
   input wire logic write_enable_latch_i,
   input wire logic protect_level_hi_i,
   input wire logic protect_level_lo_i,
   input wire logic nv_lock_i,
   output logic wel_set_o,
   output logic nv_lock_write_o,
   output logic locked_o,
   output logic sector_data_op_o,
   output logic sector_write_ok_o
);
   // ********************************
   // Pin synchronisers
   // ********************************
   logic [2:0] s1_q, s2_q;
   logic sclk_prev_q, sel_prev_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // Idle pin levels (select high, clock low), so no false edge follows reset
         s1_q <= 3'h4;
         s2_q <= 3'h4;
         sclk_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
      end else if (clk_en_i) begin
         s1_q <= {select_n_i, sclk_i, serial_in_i};
         s2_q <= s1_q;
         sclk_prev_q <= s2_q[1];
         sel_prev_q <= s2_q[2];
      end
   end
   wire sel_n = s2_q[2];
   wire sdi = s2_q[0];
   wire rise = !sel_n && s2_q[1] && !sclk_prev_q; // [R15]
   wire fall = !sel_n && !s2_q[1] && sclk_prev_q; // [R15]
   wire sel_up = sel_n && !sel_prev_q;

   // ********************************
   // Shift-in and decode
   // ********************************
   typedef enum logic [2:0] {ST_CMD, ST_LOCKWAIT, ST_STATUS, ST_UID, ST_IGNORE} ssl_state_e;
   ssl_state_e st_q;
   logic [5:0] cnt_q;
   logic [31:0] sh_q;
   logic [7:0] out_q;
   logic [2:0] bit_q;
   logic [3:0] idx_q;
   logic lock_q, dout_q, den_q, wel_q, nvw_q, sdo_q, lock_ok_q;
   wire [31:0] sh_nx = {sh_q[30:0], sdi};
   wire [7:0] op = sh_nx[23:16];
   wire [1:0] region_select_bits = sh_nx[10:9];
   wire uid_sel = sh_nx[ssl_pkg::ADDR_UID_BIT]; // [R19]
   wire hdr_done = cnt_q == 6'(ssl_pkg::HDR_BITS - 1);
   wire is_status = op == ssl_pkg::OP_READ && !uid_sel
      && region_select_bits == ssl_pkg::SEL_LOCK; // [R8]
   wire is_uid = op == ssl_pkg::OP_READ && uid_sel; // [R11] [R19]
   wire is_data = (op == ssl_pkg::OP_READ && !uid_sel || op == ssl_pkg::OP_LOCK)
      && region_select_bits == ssl_pkg::SEL_DATA; // [R17]
   wire lock_hdr = op == ssl_pkg::OP_LOCK && region_select_bits == ssl_pkg::SEL_LOCK; // [R3]
   wire lock_byte = cnt_q == 6'(ssl_pkg::LOCK_BITS - 1);
   wire lock_allowed = write_enable_latch_i && !lock_q
      && !(protect_level_hi_i && protect_level_lo_i); // [R1] [R6]
   wire [7:0] status_byte = 8'(lock_q) << ssl_pkg::STATUS_LOCK_BIT; // [R9]
   wire [7:0] uid_byte = UID_VALUE[127 - 8 * idx_q -: 8];
   wire [3:0] idx_nx = idx_q + 4'h1; // [R13]

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_CMD;
         cnt_q <= 6'h00;
         sh_q <= 32'h0;
         lock_ok_q <= 1'b0;
      end else if (clk_en_i) begin
         // Select high abandons any half-received instruction
         if (sel_n) begin
            st_q <= ST_CMD; // [R14]
            cnt_q <= 6'h00;
            lock_ok_q <= 1'b0;
         end else if (rise) begin
            sh_q <= sh_nx;
            if (cnt_q != 6'h3F)
               cnt_q <= cnt_q + 6'h01;
            lock_ok_q <= 1'b0;
            case (st_q)
               ST_CMD: begin
                  if (cnt_q == 6'(ssl_pkg::OP_BITS - 1) && sh_nx[7:0] != ssl_pkg::OP_READ
                      && sh_nx[7:0] != ssl_pkg::OP_LOCK)
                     st_q <= ST_IGNORE;
                  else if (hdr_done) begin
                     if (is_status) st_q <= ST_STATUS;
                     else if (is_uid) st_q <= ST_UID;
                     else if (lock_hdr) st_q <= ST_LOCKWAIT;
                     else st_q <= ST_IGNORE;
                  end
               end
               ST_LOCKWAIT: begin
                  // Only the edge of the eighth bit arms the lock
                  lock_ok_q <= lock_byte && sh_nx[ssl_pkg::LOCK_DATA_BIT]; // [R4] [R5]
                  if (!lock_byte) st_q <= ST_LOCKWAIT;
                  if (cnt_q > 6'(ssl_pkg::LOCK_BITS - 1)) st_q <= ST_IGNORE; // [R5]
               end
               default: st_q <= st_q;
            endcase
         end
      end
   end

   // ********************************
   // Output shifting and lock store
   // ********************************
   // 06h only counts when exactly eight bits came before select high;
   // the state has already moved on to ignore, so it is not consulted
   wire wren_done = sel_up && cnt_q == 6'(ssl_pkg::OP_BITS)
      && sh_q[7:0] == ssl_pkg::OP_WREN; // [R16]
   // lock_ok_q still holds the frame's verdict in the cycle select is seen high
   wire lock_commit = sel_up && lock_ok_q && lock_allowed; // [R1] [R5] [R6]
   // Output runs only in the two read states; sector data is handled elsewhere
   wire out_state = st_q == ST_STATUS || st_q == ST_UID;
   wire [7:0] next_byte = st_q == ST_STATUS ? status_byte : uid_byte; // [R10] [R12]

   // Lock store: latch and lock requests leave as single-cycle pulses
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wel_q <= 1'b0;
         nvw_q <= 1'b0;
         lock_q <= ssl_pkg::LOCK_RESET;
      end else if (clk_en_i) begin
         wel_q <= wren_done; // [R16]
         // One-cycle pulse; the store must hold it and feed it back
         nvw_q <= lock_commit; // [R18]
         // Only ever set, so no later instruction can unlock
         lock_q <= nv_lock_i | lock_q | lock_commit; // [R7] [R18]
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_q <= 8'h00;
         bit_q <= 3'h0;
         idx_q <= 4'h0;
         dout_q <= 1'b0;
         den_q <= 1'b0;
         sdo_q <= 1'b0;
      end else if (clk_en_i) begin
         sdo_q <= 1'b0;
         if (sel_n) begin
            den_q <= 1'b0; // [R14]
            bit_q <= 3'h0;
         end else if (rise && st_q == ST_CMD && hdr_done) begin
            idx_q <= sh_nx[3:0]; // [R11]
            sdo_q <= is_data; // [R17]
         end else if (fall && out_state) begin
            den_q <= 1'b1;
            // Reloaded at bit 0, so status repeats and the serial advances
            if (bit_q == 3'h0) begin
               out_q <= next_byte;
               dout_q <= next_byte[7]; // [R15]
            end else begin
               dout_q <= out_q[3'h7 - bit_q];
            end
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7 && st_q == ST_UID) begin
               idx_q <= idx_nx; // [R13]
            end
         end
      end
   end

   assign serial_out_o = dout_q;
   assign serial_out_en_o = den_q;
   assign wel_set_o = wel_q;
   assign nv_lock_write_o = nvw_q;
   assign locked_o = lock_q;
   assign sector_data_op_o = sdo_q;

   // ********************************
   // Sector write gate
   // ********************************
   // Registered so the gate stays glitch-free while protect bits move
   logic swok_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         swok_q <= 1'b0;
      end else if (clk_en_i) begin
         swok_q <= !lock_q && !(protect_level_hi_i && protect_level_lo_i); // [R7]
      end
   end
   assign sector_write_ok_o = swok_q;
endmodule // ssl_core

// *** ssl_pkg.sv ***
// Constants for the security-region lock and unique-serial block.
// Assumes an SPI mode 0/3 host and a 100 MHz system clock.
package ssl_pkg;
   // ********************************
   // Opcodes and address decode
   // ********************************
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_LOCK = 8'h82;
   localparam logic [7:0] OP_READ = 8'h83;
   localparam logic [1:0] SEL_LOCK = 2'h2;
   localparam logic [1:0] SEL_DATA = 2'h0;
   localparam int ADDR_UID_BIT = 9;
   localparam int LOCK_DATA_BIT = 1;
   localparam int STATUS_LOCK_BIT = 1;
   // ********************************
   // Framing counts
   // ********************************
   localparam int OP_BITS = 8;
   localparam int HDR_BITS = 24;
   localparam int LOCK_BITS = 32;
   localparam int UID_BYTES = 16;
   localparam logic LOCK_RESET = 1'b0;
   // Arbitrary serial value, not any real part
   localparam logic [127:0] UID_DEFAULT = 128'h0123456789ABCDEF_FEDCBA9876543210;
endpackage

// *** ssl_core_sva.sv ***
// Checker for the lock and serial-read block.
// Assumes it is bound into the block and sees its pins unsynchronised.
`timescale 1ns/100ps
module ssl_core_sva (
   // Clock and pins
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic select_n_i,
   input wire logic write_enable_latch_i,
   input wire logic protect_level_hi_i,
   input wire logic protect_level_lo_i,
   // Results
   input wire logic serial_out_en_o,
   input wire logic wel_set_o,
   input wire logic nv_lock_write_o,
   input wire logic locked_o
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_lock_needs_wel: assert property (nv_lock_write_o |-> $past(write_enable_latch_i))
      else $error("lock without latch");
   chk_lock_not_protected: assert property (nv_lock_write_o |->
      !($past(protect_level_hi_i) && $past(protect_level_lo_i)))
      else $error("lock while protected");
   chk_lock_not_twice: assert property (nv_lock_write_o |-> !$past(locked_o))
      else $error("lock while locked");
   chk_lock_sets_state: assert property (nv_lock_write_o |=> locked_o)
      else $error("lock state not set");
   chk_lock_is_sticky: assert property (locked_o |=> locked_o) else $error("lock cleared");
   chk_deselect_releases: assert property ($rose(select_n_i) |-> ##[1:6] !serial_out_en_o)
      else $error("output still driven");
   chk_wel_after_frame: assert property (wel_set_o |-> select_n_i && $past(select_n_i, 2))
      else $error("latch set inside frame");
   chk_lock_after_frame: assert property (nv_lock_write_o |-> $past(select_n_i, 2))
      else $error("lock inside frame");
   chk_drive_in_frame: assert property ($rose(serial_out_en_o) |-> !select_n_i)
      else $error("drive outside frame");
   cover property (nv_lock_write_o);
   cover property (wel_set_o);
   cover property ($rose(serial_out_en_o));
endmodule // ssl_core_sva

// *** ssl_host.sv ***
// SPI host model, mode 0, 125 ns clock.
// Assumes the device samples on rising and drives on falling clock.
`timescale 1ns/100ps
module ssl_host (
   // Toward the device
   output logic select_n_o,
   output logic sclk_o,
   output logic serial_in_o,
   // From the device
   input wire logic serial_out_i
);
   initial begin
      select_n_o = 1'b1;
      sclk_o = 1'b0;
      serial_in_o = 1'b0;
   end
   // Clock stands still outside frames
   task automatic frame(input logic [39:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      select_n_o = 1'b0;
      #62.5;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_o = tx[i];
         #62.5 sclk_o = 1'b1;
         rx = {rx[14:0], serial_out_i};
         #62.5 sclk_o = 1'b0;
      end
      #30 select_n_o = 1'b1;
      // Released line must not keep its last level
      serial_in_o = ~serial_in_o;
      #200;
   endtask
endmodule // ssl_host

// *** ssl_core_bench.sv ***
// Bench for the lock and serial-read block.
// Assumes latch and nonvolatile store live here, beside the block.
`timescale 1ns/100ps
module ssl_core_bench;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wel_q = 1'b0;
   logic prot_hi_q = 1'b0;
   logic prot_lo_q = 1'b0;
   logic en_q = 1'b1;
   logic sdo_en, data_op, wr_ok;
   logic [15:0] data_op_cnt = 16'h0000;
   logic [15:0] en_cnt = 16'h0000;
   logic nv_q = 1'b0;
   logic sel_n, sclk, sdi, sdo, wel_set, nv_wr, locked;
   logic [15:0] rx;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   // Arbitrary serial value
   localparam logic [127:0] UNIQUE_SERIAL = 128'hA1B2C3D4E5F60718_293A4B5C6D7E8F90;
   always #5 clk_i = ~clk_i;
   ssl_host u_host (.select_n_o(sel_n), .sclk_o(sclk), .serial_in_o(sdi), .serial_out_i(sdo));
   ssl_core #(.UID_VALUE(UNIQUE_SERIAL)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en_q),
      .select_n_i(sel_n), .sclk_i(sclk), .serial_in_i(sdi), .serial_out_o(sdo),
      .serial_out_en_o(sdo_en), .write_enable_latch_i(wel_q), .protect_level_hi_i(prot_hi_q),
      .protect_level_lo_i(prot_lo_q), .nv_lock_i(nv_q), .wel_set_o(wel_set),
      .nv_lock_write_o(nv_wr), .locked_o(locked), .sector_data_op_o(data_op),
      .sector_write_ok_o(wr_ok));
   always @(posedge clk_i) begin
      wel_q <= wel_q | wel_set;
      nv_q <= nv_q | nv_wr;
      data_op_cnt <= data_op_cnt + 16'(data_op);
      en_cnt <= en_cnt + 16'(sdo_en);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Extra or missing bits come from shifting the frame
   task automatic lock(input logic [15:0] a, input logic [7:0] d, input int n, input logic e);
      u_host.frame({8'h82, a, d, 8'h00} >> (40 - n), n, rx);
      chk({15'h0000, locked}, {15'h0000, e});
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] n0;
      n0 = en_cnt;
      u_host.frame({8'h83, a, 16'h0000}, 40, rx);
      chk(rx, e);
      chk({15'h0000, sdo_en}, 16'h0000);
      chk({15'h0000, en_cnt != n0}, 16'h0001);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk({15'h0000, wr_ok}, 16'h0001);
      rd(16'h0400, 16'h0000);
      lock(16'h0400, 8'h02, 32, 1'b0);
      // Frozen block must miss the whole instruction
      @(posedge clk_i) en_q <= 1'b0;
      u_host.frame(40'h06, 8, rx);
      @(posedge clk_i) en_q <= 1'b1;
      chk({15'h0000, wel_q}, 16'h0000);
      u_host.frame(40'h06, 8, rx);
      chk({15'h0000, wel_q}, 16'h0001);
      @(posedge clk_i) begin
         prot_hi_q <= 1'b1;
         prot_lo_q <= 1'b1;
      end
      lock(16'h0400, 8'h02, 32, 1'b0);
      chk({15'h0000, wr_ok}, 16'h0000);
      @(posedge clk_i) prot_lo_q <= 1'b0;
      $display("refusals done");
      lock(16'h0000, 8'h02, 32, 1'b0);
      chk(data_op_cnt, 16'h0001);
      chk({15'h0000, wr_ok}, 16'h0001);
      lock(16'h0200, 8'h02, 32, 1'b0);
      lock(16'h0400, 8'hFD, 32, 1'b0);
      lock(16'h0400, 8'h02, 33, 1'b0);
      lock(16'h0400, 8'h02, 31, 1'b0);
      lock(16'hFDFF, 8'hFE, 32, 1'b1);
      @(posedge clk_i) prot_hi_q <= 1'b0;
      lock(16'h0400, 8'h02, 32, 1'b1);
      chk({15'h0000, wr_ok}, 16'h0000);
      $display("lock done");
      rd(16'hFDFF, 16'h0202);
      rd(16'h020F, {UNIQUE_SERIAL[7:0], UNIQUE_SERIAL[127:120]});
      rd(16'hFE01, UNIQUE_SERIAL[119:104]);
      chk(data_op_cnt, 16'h0001);
      $display("reads done");
      print_verdict();
   end
endmodule // ssl_core_bench
bind ssl_core ssl_core_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .select_n_i(select_n_i),
   .write_enable_latch_i(write_enable_latch_i), .protect_level_hi_i(protect_level_hi_i),
   .protect_level_lo_i(protect_level_lo_i), .serial_out_en_o(serial_out_en_o),
   .wel_set_o(wel_set_o), .nv_lock_write_o(nv_lock_write_o), .locked_o(locked_o));
